/* core/hlpc_pkg.sv */
package hlpc_pkg;

    // Register word indices; byte address is four times the index
    localparam logic [5:0]  HLPC_IDX_CONF   = 6'h01;
    localparam logic [5:0]  HLPC_IDX_ACTUAL = 6'h10;
    localparam logic [5:0]  HLPC_IDX_TARGET = 6'h11;
    localparam logic [5:0]  HLPC_IDX_RANGE  = 6'h12;
    localparam logic [5:0]  HLPC_IDX_LATCH  = 6'h13;
    localparam logic [5:0]  HLPC_IDX_HOME   = 6'h14;
    localparam logic [5:0]  HLPC_IDX_STATUS = 6'h15;
    localparam logic [5:0]  HLPC_IDX_MASK   = 6'h16;
    localparam logic [1:0]  HLPC_ADDR_LANE  = 2'h0;

    localparam logic [31:0] HLPC_CONF_RESET  = 32'h0000_0000;
    localparam logic [31:0] HLPC_WORD_ZERO   = 32'h0000_0000;
    localparam logic [31:0] HLPC_RANGE_RESET = 32'h7FFF_FFFF;
    localparam logic [31:0] HLPC_ONE         = 32'h0000_0001;

    // Configuration field positions
    localparam int HLPC_BIT_LATCH_R_INACT = 12;
    localparam int HLPC_BIT_LATCH_R_ACT   = 13;
    localparam int HLPC_BIT_LEFT_HOME     = 14;
    localparam int HLPC_BIT_RIGHT_HOME    = 15;
    localparam int HLPC_SEL_LSB           = 16;
    localparam int HLPC_SEL_MSB           = 19;
    localparam int HLPC_BIT_TRACK         = 20;
    localparam int HLPC_BIT_CLR_TGT       = 21;
    localparam int HLPC_BIT_MODULO        = 22;

    // Home event selection encodings
    localparam logic [3:0] HLPC_HOME_HI_RISE = 4'h3;
    localparam logic [3:0] HLPC_HOME_HI_FALL = 4'h4;
    localparam logic [3:0] HLPC_HOME_HI_MID  = 4'h6;
    localparam logic [3:0] HLPC_HOME_LO_MID  = 4'h9;
    localparam logic [3:0] HLPC_HOME_LO_RISE = 4'hB;
    localparam logic [3:0] HLPC_HOME_LO_FALL = 4'hD;

    // Event bits of status and mask
    localparam int HLPC_EVT_W          = 3;
    localparam int HLPC_EVT_LATCH_DONE = 0;
    localparam int HLPC_EVT_STOP_LATCH = 1;
    localparam int HLPC_EVT_TARGET     = 2;

    localparam int HLPC_PIN_W     = 3;
    localparam int HLPC_PIN_LEFT  = 0;
    localparam int HLPC_PIN_RIGHT = 1;
    localparam int HLPC_PIN_HOME  = 2;

    typedef enum logic [1:0]
    {
        HLPC_PLACE_NONE = 2'h0,
        HLPC_PLACE_RISE = 2'h1,
        HLPC_PLACE_MID  = 2'h3,
        HLPC_PLACE_FALL = 2'h2
    } hlpc_place_t;

    typedef enum logic
    {
        HLPC_HS_OUTSIDE = 1'b0,
        HLPC_HS_INSIDE  = 1'b1
    } hlpc_home_state_t;

    function automatic hlpc_place_t hlpc_place(input logic [3:0] sel);
        unique case (sel)
            HLPC_HOME_HI_RISE, HLPC_HOME_LO_RISE: return HLPC_PLACE_RISE;
            HLPC_HOME_HI_FALL, HLPC_HOME_LO_FALL: return HLPC_PLACE_FALL;
            HLPC_HOME_HI_MID, HLPC_HOME_LO_MID:   return HLPC_PLACE_MID;
            default:                              return HLPC_PLACE_NONE;
        endcase
    endfunction

    function automatic logic hlpc_low_active(input logic [3:0] sel);
        return (sel == HLPC_HOME_LO_MID) || (sel == HLPC_HOME_LO_RISE)
            || (sel == HLPC_HOME_LO_FALL);
    endfunction

endpackage

/* core/hlpc_home_if.sv */
`timescale 1ns/1ps
interface hlpc_home_if;
    logic        home_ref;
    logic        move_up;
    logic [31:0] actual;
    logic [3:0]  event_sel;
    logic        home_event;
    logic [31:0] home_pos;

    modport detect
    (
        input  home_ref,
        input  move_up,
        input  actual,
        input  event_sel,
        output home_event,
        output home_pos
    );

    modport ctrl
    (
        output home_ref,
        output move_up,
        output actual,
        output event_sel,
        input  home_event,
        input  home_pos
    );
endinterface

/* core/hlpc_home_detect.sv */
`timescale 1ns/1ps
module hlpc_home_detect
    import hlpc_pkg::*;
(
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    hlpc_home_if.detect hif
);

    hlpc_place_t       place;
    hlpc_home_state_t  state;
    logic              active;
    logic              active_d;
    logic              enter;
    logic              leave;
    logic [31:0]       entry_pos;
    logic [32:0]       mid_sum;

    assign place   = hlpc_place(hif.event_sel);
    // Low-active encodings invert the reference level
    assign active  = (place != HLPC_PLACE_NONE)
                   && (hif.home_ref ^ hlpc_low_active(hif.event_sel));
    assign enter   = active && !active_d;
    assign leave   = !active && active_d;
    assign mid_sum = {entry_pos[31], entry_pos} + {hif.actual[31], hif.actual};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            active_d <= 1'b0;
        else
            active_d <= active;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= HLPC_HS_OUTSIDE;
            entry_pos <= HLPC_WORD_ZERO;
        end
        else
        begin
            unique case (state)
                HLPC_HS_OUTSIDE:
                    if (enter)
                    begin
                        state     <= HLPC_HS_INSIDE;
                        entry_pos <= hif.actual;
                    end
                HLPC_HS_INSIDE:
                    if (leave || !active)
                        state <= HLPC_HS_OUTSIDE;
            endcase
        end
    end

    // Rising edge of the range is its lower position end, whichever way
    // the motor travels through it
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hif.home_event <= 1'b0;
            hif.home_pos   <= HLPC_WORD_ZERO;
        end
        else
        begin
            hif.home_event <= 1'b0;
            unique case (place)
                HLPC_PLACE_RISE:
                    if ((enter && hif.move_up) || (leave && !hif.move_up))
                    begin
                        hif.home_event <= 1'b1;
                        hif.home_pos   <= hif.actual;
                    end
                HLPC_PLACE_FALL:
                    if ((leave && hif.move_up) || (enter && !hif.move_up))
                    begin
                        hif.home_event <= 1'b1;
                        hif.home_pos   <= hif.actual;
                    end
                HLPC_PLACE_MID:
                    if (leave && state == HLPC_HS_INSIDE)
                    begin
                        hif.home_event <= 1'b1;
                        hif.home_pos   <= mid_sum[32:1];
                    end
                HLPC_PLACE_NONE:
                    hif.home_event <= 1'b0;
            endcase
        end
    end

endmodule

/* core/hlpc_top.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - Right stop going inactive copies actual position to latch when enabled.
// - Right stop going active copies actual position into latch when enabled.
// - Left stop also feeds the home reference when its home bit is set.
// - Right stop also feeds the home reference when its home bit is set.
// - Encoding 6 high-active, 9 low-active; home sits mid active range.
// - Encodings 3 and 11 put home at rising edge; 11 is low-active.
// - Encodings 4 and 13 put home at falling edge; 13 is low-active.
// - Tracking bit clear means the home register is never updated.
// - Tracking bit set stores position at next home event, raises latch-done.
// - Clearing that latch-done event also clears the tracking bit.
// - Without clear-at-target, positioning holds at the target.
// - With clear-at-target, position goes to zero and next ramp starts.
// - Modulo off lets position use the full signed 32-bit range.
// - Modulo on keeps position between minus limit and limit minus one.
module hlpc_top
    import hlpc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire logic        left_stop_input,
    input  wire logic        right_stop_input,
    input  wire logic        home_ref_input,
    input  wire logic        step_pulse,
    input  wire logic        step_dir,
    input  wire logic        positioning_mode,
    output logic             irq,
    output logic             hold_at_target,
    output logic             ramp_restart,
    output logic      [31:0] actual_position
);

    logic                  rst_meta;
    logic                  rst_n;
    logic [HLPC_PIN_W-1:0] pin_raw;
    logic [HLPC_PIN_W-1:0] pin_meta;
    logic [HLPC_PIN_W-1:0] pin_sync;
    logic                  right_d;
    logic [31:0]           reference_switch_config;
    logic [31:0]           target_position;
    logic [31:0]           range_limit;
    logic [31:0]           position_latch;
    logic [31:0]           home_position;
    logic [HLPC_EVT_W-1:0] evt_status;
    logic [HLPC_EVT_W-1:0] evt_mask;
    logic [HLPC_EVT_W-1:0] evt_set;
    logic [HLPC_EVT_W-1:0] evt_clr;
    logic                  track_pending;
    logic                  move_up;
    logic                  at_target;
    logic                  at_target_d;
    logic                  target_hit;
    logic                  wr_conf;
    logic                  wr_actual;
    logic                  wr_status;
    logic                  right_rise;
    logic                  right_fall;
    logic                  track_capture;
    logic                  track_release;
    logic [31:0]           next_position;
    logic [31:0]           neg_limit;
    logic [31:0]           top_limit;

    hlpc_home_if hif();

    function automatic logic hit(input logic [5:0] idx);
        return (bus_addr[7:2] == idx) && (bus_addr[1:0] == HLPC_ADDR_LANE);
    endfunction

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign pin_raw[HLPC_PIN_LEFT]  = left_stop_input;
    assign pin_raw[HLPC_PIN_RIGHT] = right_stop_input;
    assign pin_raw[HLPC_PIN_HOME]  = home_ref_input;

    // Switch pins are asynchronous; only the second stage is read
    for (genvar i = 0; i < HLPC_PIN_W; i++)
    begin : g_sync
        always_ff @(posedge core_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                pin_meta[i] <= 1'b0;
                pin_sync[i] <= 1'b0;
            end
            else
            begin
                pin_meta[i] <= pin_raw[i];
                pin_sync[i] <= pin_meta[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            right_d <= 1'b0;
        else
            right_d <= pin_sync[HLPC_PIN_RIGHT];
    end

    assign right_rise = pin_sync[HLPC_PIN_RIGHT] && !right_d;
    assign right_fall = !pin_sync[HLPC_PIN_RIGHT] && right_d;

    assign wr_conf   = bus_wr && hit(HLPC_IDX_CONF);
    assign wr_actual = bus_wr && hit(HLPC_IDX_ACTUAL);
    assign wr_status = bus_wr && hit(HLPC_IDX_STATUS);

    // Home reference combines the dedicated pin with optional stops
    assign hif.home_ref = pin_sync[HLPC_PIN_HOME]
        || (pin_sync[HLPC_PIN_LEFT]
            && reference_switch_config[HLPC_BIT_LEFT_HOME])
        || (pin_sync[HLPC_PIN_RIGHT]
            && reference_switch_config[HLPC_BIT_RIGHT_HOME]);
    assign hif.move_up   = move_up;
    assign hif.actual    = actual_position;
    assign hif.event_sel =
        reference_switch_config[HLPC_SEL_MSB:HLPC_SEL_LSB];

    hlpc_home_detect u_home
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .hif      (hif)
    );

    // Single shot: once captured, later home events wait for a new start
    assign track_capture = hif.home_event && !track_pending
        && reference_switch_config[HLPC_BIT_TRACK];
    assign evt_clr = wr_status ? bus_wdata[HLPC_EVT_W-1:0]
                               : {HLPC_EVT_W{1'b0}};
    // A capture in the clearing cycle keeps the start bit alive
    assign track_release = track_pending && !track_capture
        && evt_clr[HLPC_EVT_LATCH_DONE];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reference_switch_config <= HLPC_CONF_RESET;
        else if (wr_conf)
            reference_switch_config <= bus_wdata;
        else if (track_release)
            reference_switch_config[HLPC_BIT_TRACK] <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            track_pending <= 1'b0;
        else if (track_capture)
            track_pending <= 1'b1;
        else if (track_release
                 || !reference_switch_config[HLPC_BIT_TRACK])
            track_pending <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            home_position <= HLPC_WORD_ZERO;
        else if (track_capture)
            home_position <= hif.home_pos;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            position_latch <= HLPC_WORD_ZERO;
        else if ((right_fall
                  && reference_switch_config[HLPC_BIT_LATCH_R_INACT])
                 || (right_rise
                  && reference_switch_config[HLPC_BIT_LATCH_R_ACT]))
            position_latch <= actual_position;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            target_position <= HLPC_WORD_ZERO;
            range_limit     <= HLPC_RANGE_RESET;
        end
        else
        begin
            if (bus_wr && hit(HLPC_IDX_TARGET))
                target_position <= bus_wdata;
            if (bus_wr && hit(HLPC_IDX_RANGE))
                range_limit <= bus_wdata;
        end
    end

    assign neg_limit = HLPC_WORD_ZERO - range_limit;
    assign top_limit = range_limit - HLPC_ONE;

    // Step counting; wrap only applies in modulo mode
    always_comb
    begin
        next_position = actual_position;
        if (step_pulse)
        begin
            if (!reference_switch_config[HLPC_BIT_MODULO])
                next_position = step_dir ? actual_position + HLPC_ONE
                                         : actual_position - HLPC_ONE;
            else if (step_dir)
                next_position =
                    ($signed(actual_position) >= $signed(top_limit))
                    ? neg_limit : actual_position + HLPC_ONE;
            else
                next_position =
                    ($signed(actual_position) <= $signed(neg_limit))
                    ? top_limit : actual_position - HLPC_ONE;
        end
    end

    assign at_target  = positioning_mode
                     && (actual_position == target_position);
    assign target_hit = at_target && !at_target_d;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            at_target_d <= 1'b0;
        else
            at_target_d <= at_target;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            move_up <= 1'b1;
        else if (step_pulse)
            move_up <= step_dir;
    end

    // Clearing at target takes priority over a step in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            actual_position <= HLPC_WORD_ZERO;
        else if (wr_actual)
            actual_position <= bus_wdata;
        else if (target_hit
                 && reference_switch_config[HLPC_BIT_CLR_TGT])
            actual_position <= HLPC_WORD_ZERO;
        else
            actual_position <= next_position;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_at_target <= 1'b0;
            ramp_restart   <= 1'b0;
        end
        else
        begin
            hold_at_target <= at_target
                && !reference_switch_config[HLPC_BIT_CLR_TGT];
            ramp_restart   <= target_hit
                && reference_switch_config[HLPC_BIT_CLR_TGT];
        end
    end

    always_comb
    begin
        evt_set = {HLPC_EVT_W{1'b0}};
        evt_set[HLPC_EVT_LATCH_DONE] = track_capture;
        evt_set[HLPC_EVT_STOP_LATCH] =
            (right_fall && reference_switch_config[HLPC_BIT_LATCH_R_INACT])
            || (right_rise && reference_switch_config[HLPC_BIT_LATCH_R_ACT]);
        evt_set[HLPC_EVT_TARGET] = target_hit;
    end

    // Set beats a write-one-to-clear landing in the same cycle
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            evt_status <= {HLPC_EVT_W{1'b0}};
        else
            evt_status <= (evt_status & ~evt_clr) | evt_set;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            evt_mask <= {HLPC_EVT_W{1'b0}};
        else if (bus_wr && hit(HLPC_IDX_MASK))
            evt_mask <= bus_wdata[HLPC_EVT_W-1:0];
    end

    // Follows status with one cycle of delay, but stays a clean flop output
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(evt_status & evt_mask);
    end

    // Read data is valid only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus_rdata <= HLPC_WORD_ZERO;
        else if (!bus_rd)
            bus_rdata <= HLPC_WORD_ZERO;
        else if (hit(HLPC_IDX_CONF))
            bus_rdata <= reference_switch_config;
        else if (hit(HLPC_IDX_ACTUAL))
            bus_rdata <= actual_position;
        else if (hit(HLPC_IDX_TARGET))
            bus_rdata <= target_position;
        else if (hit(HLPC_IDX_RANGE))
            bus_rdata <= range_limit;
        else if (hit(HLPC_IDX_LATCH))
            bus_rdata <= position_latch;
        else if (hit(HLPC_IDX_HOME))
            bus_rdata <= home_position;
        else if (hit(HLPC_IDX_STATUS))
            bus_rdata <= {{(32-HLPC_EVT_W){1'b0}}, evt_status};
        else if (hit(HLPC_IDX_MASK))
            bus_rdata <= {{(32-HLPC_EVT_W){1'b0}}, evt_mask};
        else
            bus_rdata <= HLPC_WORD_ZERO;
    end

endmodule

/* test/hlpc_switch_model.sv */
`timescale 1ns/1ps
// Stop and home switches; levels follow cmd after LAG clocks plus skew
module hlpc_switch_model
    import hlpc_pkg::*;
#(
    parameter int LAG = 2
)
(
    input  wire logic [2:0] cmd,
    input  wire logic       core_clk,
    output logic            left_stop_input,
    output logic            right_stop_input,
    output logic            home_ref_input
);
    logic [3*LAG-1:0] sh;

    initial sh = '0;
    always @(posedge core_clk)
        sh <= {sh[3*LAG-4:0], cmd};
    // Skew keeps pin edges away from the sampling edge
    assign #3 left_stop_input  = sh[3*LAG-3+HLPC_PIN_LEFT];
    assign #3 right_stop_input = sh[3*LAG-3+HLPC_PIN_RIGHT];
    assign #3 home_ref_input   = sh[3*LAG-3+HLPC_PIN_HOME];
endmodule

/* test/hlpc_top_sva.sv */
`timescale 1ns/1ps
module hlpc_top_chk
    import hlpc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        step_pulse,
    input wire logic        step_dir,
    input wire logic        positioning_mode,
    input wire logic        irq,
    input wire logic        hold_at_target,
    input wire logic        ramp_restart,
    input wire logic [31:0] actual_position
);
    logic [31:0] conf_m;
    logic [31:0] range_m;
    logic [1:0]  up_cnt;
    logic        step_ok;
    logic        mod_on;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conf_m  <= HLPC_CONF_RESET;
            range_m <= HLPC_RANGE_RESET;
        end
        else if (bus_wr && bus_addr == 8'h04)
            conf_m <= bus_wdata;
        else if (bus_wr && bus_addr == 8'h48)
            range_m <= bus_wdata;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            up_cnt <= 2'h0;
        else if (up_cnt != 2'h3)
            up_cnt <= up_cnt + 2'h1;
    end

    assign step_ok = step_pulse && !bus_wr && up_cnt == 2'h3;
    assign mod_on  = conf_m[HLPC_BIT_MODULO] && !conf_m[HLPC_BIT_CLR_TGT];

    AST_STEP_FREE: assert property (
        step_ok && conf_m[22:21] == 2'b00 |=> actual_position ==
        $past(actual_position) + ($past(step_dir) ? 32'h1 : 32'hFFFF_FFFF))
        else $error("free-running step gave wrong position");
    AST_WRAP_UP: assert property (
        step_ok && mod_on && step_dir && actual_position == range_m - 32'h1
        |=> actual_position == HLPC_WORD_ZERO - range_m)
        else $error("upward wrap missed");
    AST_WRAP_DOWN: assert property (
        step_ok && mod_on && !step_dir
        && actual_position == HLPC_WORD_ZERO - range_m
        |=> actual_position == range_m - 32'h1)
        else $error("downward wrap missed");
    AST_MOD_IN: assert property (
        step_ok && mod_on |=>
        $signed(actual_position) >= -$signed(range_m)
        && $signed(actual_position) < $signed(range_m))
        else $error("position left the modulo range");
    AST_RESTART_ZERO: assert property (
        $rose(ramp_restart) |-> ##[0:1] actual_position == HLPC_WORD_ZERO)
        else $error("position not cleared at restart");
    AST_RESTART_PULSE: assert property (
        ramp_restart |=> !ramp_restart)
        else $error("restart longer than one cycle");
    AST_HOLD_XOR: assert property (
        !(hold_at_target && ramp_restart))
        else $error("hold and restart together");
    AST_HOLD_CAUSE: assert property (
        hold_at_target |-> $past(positioning_mode)
        && !$past(conf_m[HLPC_BIT_CLR_TGT]))
        else $error("hold without positioning or with clear");

    COV_RESTART: cover property (ramp_restart);
    COV_HOLD: cover property ($rose(hold_at_target));
    COV_IRQ: cover property ($rose(irq));
endmodule

bind hlpc_top hlpc_top_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .step_pulse(step_pulse),
    .step_dir(step_dir), .positioning_mode(positioning_mode), .irq(irq),
    .hold_at_target(hold_at_target), .ramp_restart(ramp_restart),
    .actual_position(actual_position));

/* test/hlpc_top_tb.sv */
`timescale 1ns/1ps
module hlpc_top_tb
    import hlpc_pkg::*;
;
    logic        core_clk, reset_n, bus_wr, bus_rd, step_pulse, step_dir;
    logic        positioning_mode, irq, hold_at_target, ramp_restart;
    logic        left_stop_input, right_stop_input, home_ref_input, lo;
    logic [7:0]  bus_addr;
    logic [31:0] bus_wdata, bus_rdata, actual_position, v;
    logic [2:0]  sw_cmd;
    logic [3:0]  sel_tab [6] = '{4'h3, 4'h4, 4'h6, 4'h9, 4'hB, 4'hD};
    int          plc [6] = '{8'h0, 8'h80, 8'h40, 8'h40, 8'h0, 8'h80};
    int          err_total, checks_done, pb, n;

    hlpc_top uut (.core_clk(core_clk), .reset_n(reset_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .left_stop_input(left_stop_input), .right_stop_input(right_stop_input),
        .home_ref_input(home_ref_input), .step_pulse(step_pulse),
        .step_dir(step_dir), .positioning_mode(positioning_mode), .irq(irq),
        .hold_at_target(hold_at_target), .ramp_restart(ramp_restart),
        .actual_position(actual_position));
    hlpc_switch_model sw (.cmd(sw_cmd), .core_clk(core_clk),
        .left_stop_input(left_stop_input), .right_stop_input(right_stop_input),
        .home_ref_input(home_ref_input));

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %0t got %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge core_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge core_clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic step(input logic d);
        @(posedge core_clk);
        step_pulse <= 1'b1;
        step_dir   <= d;
        @(posedge core_clk);
        step_pulse <= 1'b0;
        #1;
    endtask

    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        {reset_n, bus_wr, bus_rd, step_pulse, positioning_mode} = 5'h0;
        {bus_addr, bus_wdata, sw_cmd} = 43'h0;
        step_dir = 1'b1;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(8'h04, v); chk(v, 32'h0);
        rd(8'h48, v); chk(v, 32'h7FFF_FFFF);
        wr(8'hFC, 32'hFFFF_FFFF); rd(8'hFC, v); chk(v, 32'h0);
        wr(8'h4C, 32'h1234); rd(8'h4C, v); chk(v, 32'h0);
        wr(8'h04, 32'h8000_0F0F); rd(8'h04, v); chk(v, 32'h8000_0F0F);
        $display("register test done");

        wr(8'h58, 32'h2);
        wr(8'h04, 32'h0000_2000);
        wr(8'h40, 32'h55);
        sw_cmd[1] <= 1'b1; settle();
        rd(8'h4C, v); chk(v, 32'h55);
        chk(irq, 1'b1);
        wr(8'h40, 32'h66);
        sw_cmd[1] <= 1'b0; settle();
        rd(8'h4C, v); chk(v, 32'h55);
        wr(8'h54, 32'h2); repeat (2) @(posedge core_clk); #1 chk(irq, 1'b0);
        wr(8'h04, 32'h0000_1000);
        wr(8'h40, 32'h77);
        sw_cmd[1] <= 1'b1; settle();
        rd(8'h4C, v); chk(v, 32'h55);
        sw_cmd[1] <= 1'b0; settle();
        rd(8'h4C, v); chk(v, 32'h77);
        rd(8'h54, v); chk(v & 32'h2, 32'h2);
        wr(8'h58, 32'h0); repeat (2) @(posedge core_clk); #1 chk(irq, 1'b0);
        wr(8'h54, 32'h7);
        $display("latch test done");

        for (int i = 0; i < 6; i++)
        begin
            lo = i > 2;
            pb = i / 3;
            wr(8'h04, 32'h0);
            sw_cmd[pb] <= lo; settle();
            wr(8'h04, (32'h1 << (14 + i / 3)) | {12'h1, sel_tab[i], 16'h0});
            wr(8'h40, 32'h100 + i);
            sw_cmd[pb] <= !lo; settle();
            wr(8'h40, 32'h180 + i);
            sw_cmd[pb] <= lo; settle();
            rd(8'h50, v);
            chk(v, 32'h100 + plc[i] + i);
            rd(8'h54, v); chk(v & 32'h1, 32'h1);
            wr(8'h54, 32'h1); repeat (2) @(posedge core_clk);
            rd(8'h04, v); chk(v[20], 1'b0);
        end
        wr(8'h04, 32'h0003_4000);
        sw_cmd <= 3'h0; settle();
        wr(8'h40, 32'h200);
        sw_cmd[0] <= 1'b1; settle();
        sw_cmd[0] <= 1'b0; settle();
        rd(8'h50, v); chk(v, 32'h185);
        $display("home test done");

        wr(8'h04, 32'h0);
        wr(8'h40, 32'h7FFF_FFFF);
        step(1'b1); chk(actual_position, 32'h8000_0000);
        wr(8'h04, 32'h0040_0000);
        wr(8'h48, 32'h10);
        wr(8'h40, 32'hF);
        step(1'b1); chk(actual_position, 32'hFFFF_FFF0);
        step(1'b0); chk(actual_position, 32'hF);
        wr(8'h04, 32'h0020_0000);
        wr(8'h44, 32'h5);
        wr(8'h40, 32'h4);
        positioning_mode <= 1'b1;
        step(1'b1);
        for (n = 0; n < 20 && ramp_restart !== 1'b1; n++)
        begin
            @(posedge core_clk);
            #1;
        end
        if (n == 20) err_total++;
        chk(ramp_restart, 1'b1);
        repeat (2) @(posedge core_clk);
        #1 chk(actual_position, 32'h0);
        rd(8'h54, v); chk(v & 32'h4, 32'h4);
        wr(8'h04, 32'h0);
        wr(8'h40, 32'h5);
        repeat (3) @(posedge core_clk);
        #1 chk(hold_at_target, 1'b1);
        chk(actual_position, 32'h5);
        positioning_mode <= 1'b0;
        $display("position test done");
        finish_test();
    end
endmodule
